// file: verilog/swpc_cfg.svh
// constants for the switch input poll configuration block
`ifndef SWPC_CFG_SVH
`define SWPC_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SWPC_ADDR_W      6
`define SWPC_DATA_W      24
`define SWPC_CH_NUM      24
`define SWPC_CH_IDX_W    5
`define SWPC_CS_W        10
`define SWPC_POLL_CODE_W 4
`define SWPC_MS_CNT_W    17
`define SWPC_POLL_MS_W   13

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SWPC_OFF_CONFIG  6'h1A
`define SWPC_OFF_IN_EN   6'h1B
`define SWPC_OFF_CS_SEL  6'h1C

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SWPC_CFG_SWRST_BIT 0
`define SWPC_CFG_POLL_LSB  1
`define SWPC_CFG_POLL_MSB  4
`define SWPC_CFG_POLL_EN   10
`define SWPC_CFG_RUN_BIT   11
`define SWPC_CFG_WR_MASK   24'hFFFFFE
`define SWPC_CS_RW_MASK    24'h0003FF
`define SWPC_REG_RESET     24'h000000
`define SWPC_DATA_ZERO     24'h000000

// ----------------------------------------------------------------
// timing: 50 MHz clock, polling interval table in ms
// ----------------------------------------------------------------
`define SWPC_CLK_HZ      50000000
`define SWPC_MS_PER_S    1000
`define SWPC_POLL_MS_0   13'd2
`define SWPC_POLL_MS_1   13'd4
`define SWPC_POLL_MS_2   13'd8
`define SWPC_POLL_MS_3   13'd16
`define SWPC_POLL_MS_4   13'd32
`define SWPC_POLL_MS_5   13'd48
`define SWPC_POLL_MS_6   13'd64
`define SWPC_POLL_MS_7   13'd128
`define SWPC_POLL_MS_8   13'd256
`define SWPC_POLL_MS_9   13'd512
`define SWPC_POLL_MS_A   13'd1024
`define SWPC_POLL_MS_B   13'd2048
`define SWPC_POLL_MS_C   13'd4096
`define SWPC_POLL_MS_DEF 13'd8

`endif

// file: verilog/swpc_pkg.sv
// types shared by the switch input poll configuration block
package swpc_pkg;

    // scan sequencer states, one-hot
    typedef enum logic [1:0]
    {
        SWPC_SEQ_IDLE = 2'b01,
        SWPC_SEQ_SCAN = 2'b10
    } swpc_seq_e;

endpackage

// file: verilog/swpc_poll_timer.sv
// polling interval timer: ms prescaler and interval counter
`timescale 1ns/1ps
`default_nettype none
`include "swpc_cfg.svh"

module swpc_poll_timer
    import swpc_pkg::*;
#(
    parameter int CYCLES_PER_MS = `SWPC_CLK_HZ / `SWPC_MS_PER_S
)
(
    input  wire logic                           core_clk_in,
    input  wire logic                           rst_n_in,
    input  wire logic                           clear_in,
    input  wire logic                           enable_in,
    input  wire logic [`SWPC_POLL_CODE_W-1:0]   poll_code_in,
    output logic                                poll_start_out
);

    // ----------------------------------------------------------------
    // interval decode
    // ----------------------------------------------------------------
    function automatic logic [`SWPC_POLL_MS_W-1:0] swpc_interval_ms
    (
        input logic [`SWPC_POLL_CODE_W-1:0] code
    );
        logic [`SWPC_POLL_MS_W-1:0] ms;
        ms = `SWPC_POLL_MS_DEF;
        case (code)
            4'h0:    ms = `SWPC_POLL_MS_0;
            4'h1:    ms = `SWPC_POLL_MS_1;
            4'h2:    ms = `SWPC_POLL_MS_2;
            4'h3:    ms = `SWPC_POLL_MS_3;
            4'h4:    ms = `SWPC_POLL_MS_4;
            4'h5:    ms = `SWPC_POLL_MS_5;
            4'h6:    ms = `SWPC_POLL_MS_6;
            4'h7:    ms = `SWPC_POLL_MS_7;
            4'h8:    ms = `SWPC_POLL_MS_8;
            4'h9:    ms = `SWPC_POLL_MS_9;
            4'hA:    ms = `SWPC_POLL_MS_A;
            4'hB:    ms = `SWPC_POLL_MS_B;
            4'hC:    ms = `SWPC_POLL_MS_C;
            default: ms = `SWPC_POLL_MS_DEF; // unlisted codes fall back to 8 ms
        endcase
        return ms;
    endfunction

    localparam logic [`SWPC_MS_CNT_W-1:0] MS_LAST = `SWPC_MS_CNT_W'(CYCLES_PER_MS - 1);

    logic [`SWPC_MS_CNT_W-1:0]  ms_cnt_q;
    logic [`SWPC_POLL_MS_W-1:0] iv_cnt_q;
    logic                       start_q;
    wire logic [`SWPC_POLL_MS_W-1:0] iv_last;
    wire logic                       ms_done;
    wire logic                       iv_done;

    assign iv_last = swpc_interval_ms(poll_code_in) - `SWPC_POLL_MS_W'(1);
    assign ms_done = (ms_cnt_q == MS_LAST);
    assign iv_done = ms_done && (iv_cnt_q == iv_last);

    // ----------------------------------------------------------------
    // counters; held at zero while idle so each run starts a full interval
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in || clear_in || !enable_in)
        begin
            ms_cnt_q <= '0;
            iv_cnt_q <= '0;
            start_q  <= 1'b0;
        end
        else
        begin
            ms_cnt_q <= ms_done ? '0 : ms_cnt_q + `SWPC_MS_CNT_W'(1);
            if (ms_done)
                iv_cnt_q <= iv_done ? '0 : iv_cnt_q + `SWPC_POLL_MS_W'(1);
            start_q  <= iv_done;
        end
    end

    assign poll_start_out = start_q;

endmodule
`default_nettype wire

// file: verilog/swpc_top.sv
// switch input poll configuration registers and channel scan sequencer
// ----------------------------------------------------------------
// What this block does
// - poll interval code 0h-Ch picks 2..4096 ms, higher codes give 8 ms
// - writing 1 to config bit 0 soft-resets the device, 0 does nothing
// - each channel-enable bit enables its input; cleared channels are skipped
// - channel-enable register at 1Bh resets to zero, all channels disabled
// - direction bits for inputs 0-9: 0 source current, 1 sink current
// - direction register bits 23-10 read-only and read zero, 9-0 writable
// - direction register at 1Ch resets to zero, all inputs source current
// - polling-enable clear gives continuous mode, set gives interval polling
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "swpc_cfg.svh"

module swpc_top
    import swpc_pkg::*;
#(
    parameter int CYCLES_PER_MS = `SWPC_CLK_HZ / `SWPC_MS_PER_S
)
(
    input  wire logic                         core_clk_in,
    input  wire logic                         rst_n_in,
    input  wire logic                         reg_wr_en_in,
    input  wire logic                         reg_rd_en_in,
    input  wire logic [`SWPC_ADDR_W-1:0]      reg_addr_in,
    input  wire logic [`SWPC_DATA_W-1:0]      reg_wdata_in,
    output logic      [`SWPC_DATA_W-1:0]      reg_rdata_out,
    output logic      [`SWPC_CH_NUM-1:0]      channel_enable_out,
    output logic      [`SWPC_CS_W-1:0]        current_direction_bit_out,
    output logic                              run_request_out,
    output logic                              poll_enable_out,
    output logic                              soft_reset_out,
    output logic                              poll_start_out,
    output logic                              scan_active_out,
    output logic                              sample_strobe_out,
    output logic      [`SWPC_CH_IDX_W-1:0]    sample_channel_out
);

    // ----------------------------------------------------------------
    // next enabled channel at or above a start index
    // ----------------------------------------------------------------
    function automatic logic [`SWPC_CH_IDX_W:0] swpc_next_enabled
    (
        input logic [`SWPC_CH_NUM-1:0]   mask,
        input logic [`SWPC_CH_IDX_W-1:0] from
    );
        logic [`SWPC_CH_IDX_W:0] res;
        res = '0;
        for (int i = 0; i < `SWPC_CH_NUM; i++)
        begin
            if (!res[`SWPC_CH_IDX_W] && (i >= int'(from)) && mask[i])
                res = {1'b1, `SWPC_CH_IDX_W'(i)};
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // offset match, shared by the write strobes and the read mux
    // ----------------------------------------------------------------
    function automatic logic swpc_addr_hit
    (
        input logic [`SWPC_ADDR_W-1:0] addr,
        input logic [`SWPC_ADDR_W-1:0] offset
    );
        return (addr == offset);
    endfunction

    logic [`SWPC_DATA_W-1:0]   config_q;
    logic [`SWPC_CH_NUM-1:0]   in_en_q;
    logic [`SWPC_CS_W-1:0]     cs_sel_q;
    logic [`SWPC_DATA_W-1:0]   rdata_q;
    logic                      swrst_q;
    swpc_seq_e                 seq_q;
    logic [`SWPC_CH_IDX_W-1:0] ptr_q;
    logic                      strobe_q;
    logic [`SWPC_CH_IDX_W-1:0] chan_q;

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    // one compare per offset; unlisted offsets match none, so writes drop and reads give zero
    wire logic hit_cfg = swpc_addr_hit(reg_addr_in, `SWPC_OFF_CONFIG);
    wire logic hit_en  = swpc_addr_hit(reg_addr_in, `SWPC_OFF_IN_EN);
    wire logic hit_cs  = swpc_addr_hit(reg_addr_in, `SWPC_OFF_CS_SEL);
    wire logic wr_cfg  = reg_wr_en_in && hit_cfg;
    wire logic wr_en   = reg_wr_en_in && hit_en;
    wire logic wr_cs   = reg_wr_en_in && hit_cs;
    wire logic swrst_req = wr_cfg && reg_wdata_in[`SWPC_CFG_SWRST_BIT];
    wire logic run       = config_q[`SWPC_CFG_RUN_BIT];
    wire logic poll_en   = config_q[`SWPC_CFG_POLL_EN];
    wire logic [`SWPC_POLL_CODE_W-1:0] poll_code =
        config_q[`SWPC_CFG_POLL_MSB:`SWPC_CFG_POLL_LSB];
    wire logic timer_start;
    wire logic [`SWPC_DATA_W-1:0] cs_word = {{(`SWPC_DATA_W-`SWPC_CS_W){1'b0}}, cs_sel_q};
    wire logic [`SWPC_DATA_W-1:0] rd_mux =
        hit_cfg ? config_q :
        hit_en  ? in_en_q  :
        hit_cs  ? cs_word  : `SWPC_DATA_ZERO;

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // enable register resets clear
    // soft reset clears all registers; the reset bit is never stored
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in || swrst_req)
        begin
            config_q <= `SWPC_REG_RESET;
            in_en_q  <= `SWPC_REG_RESET;
            cs_sel_q <= `SWPC_CS_W'(`SWPC_REG_RESET);
        end
        else
        begin
            if (wr_cfg)
                config_q <= reg_wdata_in & `SWPC_CFG_WR_MASK;
            if (wr_en)
                in_en_q <= reg_wdata_in;
            if (wr_cs)
                cs_sel_q <= `SWPC_CS_W'(reg_wdata_in & `SWPC_CS_RW_MASK);
        end
    end

    // read data and soft reset pulse, both one cycle after the access
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            rdata_q <= `SWPC_DATA_ZERO;
            swrst_q <= 1'b0;
        end
        else
        begin
            if (reg_rd_en_in)
                rdata_q <= rd_mux;
            // reset pulse only on a 1
            swrst_q <= swrst_req;
        end
    end

    // ----------------------------------------------------------------
    // polling interval timer
    // ----------------------------------------------------------------
    // timer only runs in polling mode
    swpc_poll_timer #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_timer (
        .core_clk_in    (core_clk_in),
        .rst_n_in       (rst_n_in),
        .clear_in       (swrst_req),
        .enable_in      (run && poll_en),
        .poll_start_out (timer_start)
    ,   .poll_code_in   (poll_code)
    );

    // ----------------------------------------------------------------
    // channel scan sequencer
    // ----------------------------------------------------------------
    // skip disabled channels
    wire logic [`SWPC_CH_IDX_W:0] nxt = swpc_next_enabled(in_en_q, ptr_q);
    // continuous mode restarts at once, polling waits for the timer
    wire logic scan_go = run && (poll_en ? timer_start : 1'b1);

    // a run-request drop aborts mid-scan, so reconfiguration never sees a half cycle
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in || swrst_req || !run)
        begin
            seq_q    <= SWPC_SEQ_IDLE;
            ptr_q    <= '0;
            strobe_q <= 1'b0;
            chan_q   <= '0;
        end
        else
        begin
            strobe_q <= 1'b0;
            unique case (seq_q)
                SWPC_SEQ_IDLE:
                begin
                    ptr_q <= '0;
                    if (scan_go)
                        seq_q <= SWPC_SEQ_SCAN;
                end
                SWPC_SEQ_SCAN:
                begin
                    if (nxt[`SWPC_CH_IDX_W])
                    begin
                        strobe_q <= 1'b1;
                        chan_q   <= nxt[`SWPC_CH_IDX_W-1:0];
                        ptr_q    <= nxt[`SWPC_CH_IDX_W-1:0] + `SWPC_CH_IDX_W'(1);
                    end
                    else
                        seq_q <= SWPC_SEQ_IDLE; // no enabled channel left
                end
                default:
                    seq_q <= SWPC_SEQ_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata_out             = rdata_q;
    assign channel_enable_out        = in_en_q;
    // 0 source, 1 sink per input
    assign current_direction_bit_out = cs_sel_q;
    assign run_request_out           = run;
    assign poll_enable_out           = poll_en;
    assign soft_reset_out            = swrst_q;
    assign poll_start_out            = timer_start;
    assign scan_active_out           = (seq_q == SWPC_SEQ_SCAN);
    assign sample_strobe_out         = strobe_q;
    assign sample_channel_out        = chan_q;

endmodule
`default_nettype wire

// file: verif/swpc_top_properties.sv
// concurrent checks on the ports of the poll configuration block
`timescale 1ns/1ps
`default_nettype none
module swpc_props
#(
    parameter int CYCLES_PER_MS = 50000
)
(
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic        reg_wr_en_in,
    input wire logic        reg_rd_en_in,
    input wire logic [5:0]  reg_addr_in,
    input wire logic [23:0] reg_wdata_in,
    input wire logic [23:0] reg_rdata_out,
    input wire logic [23:0] channel_enable_out,
    input wire logic [9:0]  current_direction_bit_out,
    input wire logic        run_request_out,
    input wire logic        poll_enable_out,
    input wire logic        soft_reset_out,
    input wire logic        poll_start_out,
    input wire logic        scan_active_out,
    input wire logic        sample_strobe_out,
    input wire logic [4:0]  sample_channel_out
);
    // ------------------------------------------------------------
    // single clock domain, reset disables every check
    // ------------------------------------------------------------
    default clocking dc @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // decoded bus cycles
    wire logic swrst_wr = reg_wr_en_in && reg_addr_in == 6'h1A && reg_wdata_in[0];

    // two strobes on adjacent cycles, both inside one scan
    sequence two_strobes;
        sample_strobe_out ##1 sample_strobe_out;
    endsequence

    en_write_a: assert property (reg_wr_en_in && reg_addr_in == 6'h1B
        |=> channel_enable_out == $past(reg_wdata_in)) else $error("enable write lost");
    dir_write_a: assert property (reg_wr_en_in && reg_addr_in == 6'h1C
        |=> current_direction_bit_out == $past(reg_wdata_in[9:0])) else $error("dir write lost");
    dir_read_a: assert property (reg_rd_en_in && reg_addr_in == 6'h1C
        |=> reg_rdata_out[23:10] == 14'h0000) else $error("dir upper bits not zero");
    rst_bit_read_a: assert property (reg_rd_en_in && reg_addr_in == 6'h1A
        |=> !reg_rdata_out[0]) else $error("reset bit reads one");
    swrst_clear_a: assert property (swrst_wr |=> soft_reset_out
        && channel_enable_out == 24'h000000 && current_direction_bit_out == 10'h000
        && !run_request_out && !poll_enable_out) else $error("soft reset incomplete");
    swrst_only_a: assert property (!swrst_wr |=> !soft_reset_out)
        else $error("spurious soft reset");
    skip_off_a: assert property (sample_strobe_out
        |-> channel_enable_out[sample_channel_out]) else $error("disabled channel sampled");
    scan_order_a: assert property (two_strobes
        |-> sample_channel_out > $past(sample_channel_out)) else $error("scan not ascending");
    cont_mode_a: assert property (run_request_out && !poll_enable_out && !scan_active_out
        |=> scan_active_out || !run_request_out) else $error("continuous scan missing");
    poll_mode_a: assert property (poll_enable_out && !poll_start_out && !scan_active_out
        |=> !scan_active_out) else $error("scan without poll start");
endmodule
bind swpc_top swpc_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) swpc_props_inst (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_wr_en_in(reg_wr_en_in),
    .reg_rd_en_in(reg_rd_en_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .channel_enable_out(channel_enable_out),
    .current_direction_bit_out(current_direction_bit_out),
    .run_request_out(run_request_out), .poll_enable_out(poll_enable_out),
    .soft_reset_out(soft_reset_out), .poll_start_out(poll_start_out),
    .scan_active_out(scan_active_out), .sample_strobe_out(sample_strobe_out),
    .sample_channel_out(sample_channel_out));
`default_nettype wire

// file: verif/swpc_host_model.sv
// host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module swpc_host_model
(
    input  wire logic        core_clk_in,
    input  wire logic [23:0] reg_rdata_in,
    output var  logic        reg_wr_en_out,
    output var  logic        reg_rd_en_out,
    output var  logic [5:0]  reg_addr_out,
    output var  logic [23:0] reg_wdata_out
);
    // idle bus at time zero
    initial
    begin
        reg_wr_en_out = 1'b0;
        reg_rd_en_out = 1'b0;
        reg_addr_out  = 6'h00;
        reg_wdata_out = 24'h000000;
    end

    // one write; data line shows inverse afterwards so stale data is never trusted
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(negedge core_clk_in);
        reg_wr_en_out = 1'b1;
        reg_addr_out  = a;
        reg_wdata_out = d;
        @(negedge core_clk_in);
        reg_wr_en_out = 1'b0;
        reg_wdata_out = ~d;
    endtask

    // one read; data is registered, so valid just after the taking edge and read half a cycle later
    task automatic rd(input logic [5:0] a, output logic [23:0] d);
        @(negedge core_clk_in);
        reg_rd_en_out = 1'b1;
        reg_addr_out  = a;
        @(negedge core_clk_in);
        reg_rd_en_out = 1'b0;
        d = reg_rdata_in;
    endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking testbench for the poll configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int CPM = 4;
    logic        core_clk_in;
    logic        rst_n_in;
    logic        wr_en;
    logic        rd_en;
    logic [5:0]  addr;
    logic [23:0] wdata;
    logic [23:0] rdata;
    logic [9:0]  cdir;
    logic        swrst;
    logic        pstart;
    logic        strobe;
    logic [4:0]  chan;
    logic [23:0] chen;
    logic        run_req;
    logic        poll_en;
    logic [23:0] rv;
    int          err_total;
    int          samples_checked;
    int          cyc;
    int          n;
    int          ms_tab [16] = '{2, 4, 8, 16, 32, 48, 64, 128, 256, 512, 1024, 2048, 4096, 8, 8, 8};
    logic [4:0]  exp_ch [6] = '{5'h00, 5'h02, 5'h17, 5'h00, 5'h02, 5'h17};

    swpc_top #(.CYCLES_PER_MS(CPM)) swpc_top_inst (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_wr_en_in(wr_en),
        .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .channel_enable_out(chen), .current_direction_bit_out(cdir),
        .run_request_out(run_req), .poll_enable_out(poll_en), .soft_reset_out(swrst),
        .poll_start_out(pstart), .scan_active_out(), .sample_strobe_out(strobe),
        .sample_channel_out(chan));
    swpc_host_model swpc_host_model_inst (
        .core_clk_in(core_clk_in), .reg_rdata_in(rdata), .reg_wr_en_out(wr_en),
        .reg_rd_en_out(rd_en), .reg_addr_out(addr), .reg_wdata_out(wdata));

    // ------------------------------------------------------------
    // clock, hang guard, compare and verdict
    // ------------------------------------------------------------
    initial
    begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    // polling sweep needs about 66k cycles
    always @(posedge core_clk_in)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n_in = 1'b0;
        repeat (10) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        swpc_host_model_inst.rd(6'h1B, rv); chk(rv, 24'h000000);
        swpc_host_model_inst.rd(6'h1C, rv); chk(rv, 24'h000000);
        $display("reset values done");
        swpc_host_model_inst.wr(6'h1B, 24'hFFFFFF);
        swpc_host_model_inst.wr(6'h1C, 24'hFFFFFF);
        swpc_host_model_inst.rd(6'h1B, rv); chk(rv, 24'hFFFFFF);
        chk(chen, 24'hFFFFFF);
        swpc_host_model_inst.rd(6'h1C, rv); chk(rv, 24'h0003FF);
        chk({14'h0000, cdir}, 24'h0003FF);
        swpc_host_model_inst.wr(6'h3F, 24'h123456);
        swpc_host_model_inst.rd(6'h3F, rv); chk(rv, 24'h000000);
        $display("register access done");
        // continuous scan over channels 0, 2 and 23 only
        swpc_host_model_inst.wr(6'h1B, 24'h800005);
        swpc_host_model_inst.wr(6'h1A, 24'h000800);
        chk({22'h000000, run_req, poll_en}, 24'h000002);
        n = 0;
        repeat (60)
        begin
            @(negedge core_clk_in);
            if (strobe === 1'b1 && n < 6)
            begin
                chk({19'h00000, chan}, {19'h00000, exp_ch[n]});
                n++;
            end
        end
        chk(24'(n), 24'h000006);
        $display("continuous scan done");
        // soft reset in mid-scan, then a write with the reset bit clear
        swpc_host_model_inst.wr(6'h1A, 24'h000801);
        chk({23'h000000, swrst}, 24'h000001);
        swpc_host_model_inst.rd(6'h1B, rv); chk(rv, 24'h000000);
        swpc_host_model_inst.rd(6'h1A, rv); chk(rv, 24'h000000);
        chk({23'h000000, strobe}, 24'h000000);
        chk(chen, 24'h000000);
        swpc_host_model_inst.wr(6'h1B, 24'h00000F);
        swpc_host_model_inst.wr(6'h1A, 24'h000002);
        chk({23'h000000, swrst}, 24'h000000);
        swpc_host_model_inst.rd(6'h1B, rv); chk(rv, 24'h00000F);
        $display("soft reset done");
        // every interval code, gap between two poll starts
        for (int c = 0; c < 16; c++)
        begin
            swpc_host_model_inst.wr(6'h1A, 24'h000C00 | {19'h00000, 4'(c), 1'b0});
            chk({22'h000000, run_req, poll_en}, 24'h000003);
            while (pstart !== 1'b1) @(negedge core_clk_in);
            n = 0;
            do
            begin
                @(negedge core_clk_in);
                n++;
            end
            while (pstart !== 1'b1);
            chk(24'(n), 24'(ms_tab[c] * CPM));
            swpc_host_model_inst.wr(6'h1A, 24'h000000);
        end
        $display("polling intervals done");
        report_and_stop();
    end
endmodule
`default_nettype wire
